// ---- hdl/lbtce_core.sv ----
module lbtce_core
  import lbtce_pkg::*;
(
  input  wire logic         MCLK_I,
  input  wire logic         RST_I,
  input  wire lbtce_instr_t INSTR_I,
  input  wire logic [10:0]  PC_I,
  input  wire logic [7:0]   STATUS_I,
  input  wire logic [7:0]   FILE_RDATA_I,
  input  wire logic [7:0]   PIN_LEVEL_I,
  input  wire logic         FILE_IS_PORT_I,
  input  wire logic         PRESCALER_ON_TIMER_I,
  output logic [4:0]        FILE_RADDR_O,
  output lbtce_fwr_t        FILE_WR_O,
  output logic [7:0]        ACC_O,
  output logic              ZERO_WE_O,
  output logic              ZERO_O,
  output logic              PC_LOAD_O,
  output logic [10:0]       PC_VALUE_O,
  output logic              STACK_PUSH_O,
  output logic [10:0]       STACK_TOP_O,
  output logic              SKIP_O,
  output logic              PRESCALER_CLR_O,
  output logic              BUSY_O
);
  lbtce_state_t state_r;
  lbtce_state_t state_nxt;
  logic [7:0]   acc_r;
  logic [7:0]   acc_nxt;
  lbtce_fwr_t   fwr_r;
  lbtce_fwr_t   fwr_nxt;
  logic         zwe_r;
  logic         zwe_nxt;
  logic         z_r;
  logic         z_nxt;
  logic         pcl_r;
  logic         pcl_nxt;
  logic [10:0]  pcv_r;
  logic [10:0]  pcv_nxt;
  logic         push_r;
  logic         push_nxt;
  logic [10:0]  push_data_nxt;
  logic         skip_r;
  logic         skip_nxt;
  logic         pclr_r;
  logic         pclr_nxt;
  logic         busy_r;
  logic         busy_nxt;
  logic [7:0]   operand;
  logic [11:0]  w;
  logic [2:0]   bsel;
  logic         exec;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  assign w       = INSTR_I.word;
  assign bsel    = w[7:5];
  assign exec    = INSTR_I.valid && state_r == LBTCE_EXEC;
  assign FILE_RADDR_O = w[4:0];
  // [RQ12] Port pin sampling
  // Reading the pins avoids writing back stale latch bits of input pins.
  assign operand = FILE_IS_PORT_I ? PIN_LEVEL_I : FILE_RDATA_I;

  always_comb begin
    state_nxt     = LBTCE_EXEC;
    acc_nxt       = acc_r;
    fwr_nxt       = '0;
    zwe_nxt       = 1'b0;
    z_nxt         = z_r;
    pcl_nxt       = 1'b0;
    pcv_nxt       = pcv_r;
    push_nxt      = 1'b0;
    push_data_nxt = PC_I + PC_STEP;
    skip_nxt      = 1'b0;
    pclr_nxt      = 1'b0;
    if (exec) begin
      // [RQ15] Single cycle execution
      if (w[11:8] == OPC_AND_LIT) begin
        // [RQ1] Literal AND
        acc_nxt = acc_r & w[7:0];
        zwe_nxt = 1'b1;
        // [RQ14] Zero from result
        z_nxt   = is_zero(acc_r & w[7:0]);
      end else if (w[11:6] == OPC_AND_FILE) begin
        // [RQ2] File AND destination
        zwe_nxt = 1'b1;
        z_nxt   = is_zero(acc_r & operand);
        if (w[5]) begin
          fwr_nxt = '{we: 1'b1, addr: w[4:0], data: acc_r & operand};
        end else begin
          acc_nxt = acc_r & operand;
        end
      end else if (w[11:8] == OPC_SET_BIT) begin
        // [RQ3] Bit set
        fwr_nxt = '{we: 1'b1, addr: w[4:0], data: operand | (8'h01 << bsel)};
      end else if (w[11:8] == OPC_SKIP_CLR || w[11:8] == OPC_SKIP_SET) begin
        // [RQ4] Skip on clear
        // [RQ5] Skip on set
        if (FILE_RDATA_I[bsel] == w[8]) begin
          skip_nxt  = 1'b1;
          // [RQ6] Flush prefetched slot
          state_nxt = LBTCE_FLUSH;
        end
      end else if (w == OPC_CLEAR_ACC) begin
        // [RQ7] Clear accumulator
        acc_nxt = ACC_RESET;
        zwe_nxt = 1'b1;
        z_nxt   = 1'b1;
      end else if (w[11:8] == OPC_CALL) begin
        // [RQ8] Push return address
        push_nxt  = 1'b1;
        pcl_nxt   = 1'b1;
        // [RQ9] Literal to low byte
        // [RQ10] Page bits, bit eight cleared
        pcv_nxt   = {STATUS_I[STATUS_PAGE_LO+1:STATUS_PAGE_LO], 1'b0, w[7:0]};
        // [RQ11] Two cycle call
        state_nxt = LBTCE_FLUSH;
      end
      // [RQ13] Timer prescaler clear
      if (fwr_nxt.we && fwr_nxt.addr == TIMER_ADDR && PRESCALER_ON_TIMER_I) begin
        pclr_nxt = 1'b1;
      end
    end
    // Busy is registered so that the output comes from a flop, not from a state compare.
    busy_nxt = state_nxt == LBTCE_FLUSH;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= LBTCE_EXEC;
      acc_r   <= ACC_RESET;
      fwr_r   <= '0;
      zwe_r   <= 1'b0;
      z_r     <= 1'b0;
      pcl_r   <= 1'b0;
      pcv_r   <= PC_RESET;
      push_r  <= 1'b0;
      skip_r  <= 1'b0;
      pclr_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      fwr_r   <= fwr_nxt;
      zwe_r   <= zwe_nxt;
      z_r     <= z_nxt;
      pcl_r   <= pcl_nxt;
      pcv_r   <= pcv_nxt;
      push_r  <= push_nxt;
      skip_r  <= skip_nxt;
      pclr_r  <= pclr_nxt;
      busy_r  <= busy_nxt;
    end
  end

  lbtce_pc_stack u_stack (
    .clk_i  (MCLK_I),
    .rst_i  (RST_I),
    .push_i (push_nxt),
    .data_i (push_data_nxt),
    .top_o  (STACK_TOP_O)
  );

  assign ACC_O           = acc_r;
  assign FILE_WR_O       = fwr_r;
  assign ZERO_WE_O       = zwe_r;
  assign ZERO_O          = z_r;
  assign PC_LOAD_O       = pcl_r;
  assign PC_VALUE_O      = pcv_r;
  assign STACK_PUSH_O    = push_r;
  assign SKIP_O          = skip_r;
  assign PRESCALER_CLR_O = pclr_r;
  assign BUSY_O          = busy_r;

  // [RQ6] Flush slot check
  a_skip_flush: assert property (@(posedge MCLK_I) disable iff (RST_I) SKIP_O |-> BUSY_O && !$past(BUSY_O)) // [RQ6]
    else $error("skip without flush slot");
  // [RQ11] Call length check
  a_call_two_cycle: assert property (@(posedge MCLK_I) disable iff (RST_I) PC_LOAD_O |-> BUSY_O ##1 !BUSY_O) // [RQ11]
    else $error("call not two cycles");
  // [RQ10] Page bits check
  a_call_page: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ10]
    PC_LOAD_O |-> PC_VALUE_O[8] == 1'b0 && PC_VALUE_O[10:9] == $past(STATUS_I[6:5]))
    else $error("call page bits wrong");
  // [RQ9] Low byte check
  a_call_low: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ9]
    PC_LOAD_O |-> PC_VALUE_O[7:0] == $past(w[7:0]))
    else $error("call low byte wrong");
  // [RQ8] Return address check
  a_push_ret: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ8]
    STACK_PUSH_O |-> STACK_TOP_O == $past(PC_I) + PC_STEP && PC_LOAD_O)
    else $error("bad return address");
  // [RQ7] Clear check
  a_clear_acc: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ7]
    exec && w == OPC_CLEAR_ACC |=> ACC_O == 8'h00 && ZERO_O && ZERO_WE_O)
    else $error("clear accumulator failed");
  // [RQ1] Literal AND check
  a_and_lit: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ1]
    exec && w[11:8] == OPC_AND_LIT |=> ACC_O == ($past(acc_r) & $past(w[7:0])) && !FILE_WR_O.we)
    else $error("literal and wrong");
  // [RQ14] Zero flag check
  a_zero_flag: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ14]
    ZERO_WE_O && !FILE_WR_O.we |-> ZERO_O == (ACC_O == 8'h00))
    else $error("zero flag mismatch");
  // [RQ3] Bit set check
  a_bit_set: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ3]
    exec && w[11:8] == OPC_SET_BIT |=> FILE_WR_O.we && FILE_WR_O.data[$past(bsel)] && !ZERO_WE_O)
    else $error("bit set wrong");
  // [RQ13] Prescaler check
  a_prescale_clr: assert property (@(posedge MCLK_I) disable iff (RST_I) // [RQ13]
    PRESCALER_CLR_O |-> FILE_WR_O.we && FILE_WR_O.addr == TIMER_ADDR)
    else $error("prescaler clear spurious");

  c_skip: cover property (@(posedge MCLK_I) disable iff (RST_I) SKIP_O);
  c_call: cover property (@(posedge MCLK_I) disable iff (RST_I) PC_LOAD_O);
  c_file_and: cover property (@(posedge MCLK_I) disable iff (RST_I) FILE_WR_O.we && ZERO_WE_O);
  c_prescale: cover property (@(posedge MCLK_I) disable iff (RST_I) PRESCALER_CLR_O);
endmodule : lbtce_core

// ---- common/lbtce_pkg.sv ----
// Overview of operation
// [RQ1] Literal AND into accumulator, zero flag only
// [RQ2] File AND, destination bit selects target
// [RQ3] Bit set forces one bit, no flags
// [RQ4] Skip next when tested bit is clear
// [RQ5] Skip next when tested bit is set
// [RQ6] Skipped slot executes as no operation
// [RQ7] Clear accumulator to zero, set zero flag
// [RQ8] Call pushes program counter plus one
// [RQ9] Call loads literal into counter low byte
// [RQ10] Call takes page bits, clears bit eight
// [RQ11] Call lasts two cycles, no flags
// [RQ12] Port read-modify-write uses pin levels
// [RQ13] Timer count write clears assigned prescaler
// [RQ14] Zero flag reflects eight-bit result
// [RQ15] Other instructions finish in one cycle
package lbtce_pkg;
  localparam logic [3:0]  OPC_AND_LIT    = 4'hE;
  localparam logic [3:0]  OPC_CALL       = 4'h9;
  localparam logic [3:0]  OPC_SET_BIT    = 4'h5;
  localparam logic [3:0]  OPC_SKIP_CLR   = 4'h6;
  localparam logic [3:0]  OPC_SKIP_SET   = 4'h7;
  localparam logic [5:0]  OPC_AND_FILE   = 6'h05;
  localparam logic [11:0] OPC_CLEAR_ACC  = 12'h040;
  localparam logic [11:0] OPC_NO_OP      = 12'h000;
  localparam logic [4:0]  TIMER_ADDR     = 5'h01;
  localparam int          STATUS_PAGE_LO = 5;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [10:0] PC_RESET       = 11'h000;
  localparam logic [10:0] PC_STEP        = 11'h001;
  localparam int          MCLK_PERIOD_NS = 4;
  localparam int          CALL_CYCLES    = 2;

  typedef struct packed {
    logic       valid;
    logic [11:0] word;
  } lbtce_instr_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } lbtce_fwr_t;

  typedef enum {
    LBTCE_EXEC,
    LBTCE_FLUSH
  } lbtce_state_t;
endpackage : lbtce_pkg

// ---- hdl/lbtce_pc_stack.sv ----
module lbtce_pc_stack
  import lbtce_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic [10:0] data_i,
  output logic [10:0]      top_o
);
  logic [10:0] lvl0_r;
  logic [10:0] lvl1_r;
  logic [10:0] lvl0_nxt;
  logic [10:0] lvl1_nxt;

  // Two levels; a third push silently drops the oldest return address.
  always_comb begin
    lvl0_nxt = lvl0_r;
    lvl1_nxt = lvl1_r;
    if (push_i) begin
      lvl0_nxt = data_i;
      lvl1_nxt = lvl0_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lvl0_r <= PC_RESET;
      lvl1_r <= PC_RESET;
    end else begin
      lvl0_r <= lvl0_nxt;
      lvl1_r <= lvl1_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      top_o <= PC_RESET;
    end else begin
      top_o <= lvl0_nxt;
    end
  end
endmodule : lbtce_pc_stack

// ---- sim/tb.sv ----
module tb
  import lbtce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [11:0] w;
    logic [7:0]  fd;
    logic        port;
    logic [7:0]  pin;
    logic        we;
    logic [7:0]  data;
    logic        zwe;
    logic        skip;
    logic        pclr;
  } lbtce_row_t;

  // The accumulator only ever leaves reset at zero here, so every AND result is zero.
  localparam lbtce_row_t ROWS [13] = '{
    '{12'hEFF, 8'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0},
    '{12'h163, 8'hA5, 1'h0, 8'h00, 1'h1, 8'h00, 1'h1, 1'h0, 1'h0},
    '{12'h143, 8'hA5, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0},
    '{12'h5E4, 8'h12, 1'h0, 8'h00, 1'h1, 8'h92, 1'h0, 1'h0, 1'h0},
    '{12'h506, 8'hFF, 1'h1, 8'h40, 1'h1, 8'h41, 1'h0, 1'h0, 1'h0},
    '{12'h645, 8'h04, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0},
    '{12'h745, 8'h04, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0},
    '{12'h765, 8'h04, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0},
    '{12'h665, 8'h04, 1'h0, 8'h00, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0},
    '{12'h040, 8'h00, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0},
    '{12'h521, 8'h00, 1'h0, 8'h00, 1'h1, 8'h02, 1'h0, 1'h0, 1'h1},
    '{12'h141, 8'hFF, 1'h0, 8'h00, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0},
    '{12'h161, 8'hFF, 1'h0, 8'h00, 1'h1, 8'h00, 1'h1, 1'h0, 1'h1}
  };

  logic         mclk = 1'h0;
  logic         rst;
  lbtce_instr_t instr;
  logic [10:0]  pc;
  logic [7:0]   status;
  logic [7:0]   frd;
  logic [7:0]   pin;
  logic         is_port;
  logic         pre_on;
  logic [4:0]   raddr;
  lbtce_fwr_t   fwr;
  logic [7:0]   acc;
  logic         zwe;
  logic         zero;
  logic         pcl;
  logic [10:0]  pcv;
  logic         push;
  logic [10:0]  top;
  logic         skip;
  logic         pclr;
  logic         busy;
  int           mismatches = 0;
  int           comparisons = 0;

  lbtce_core dut (
    .MCLK_I(mclk), .RST_I(rst), .INSTR_I(instr), .PC_I(pc), .STATUS_I(status),
    .FILE_RDATA_I(frd), .PIN_LEVEL_I(pin), .FILE_IS_PORT_I(is_port),
    .PRESCALER_ON_TIMER_I(pre_on), .FILE_RADDR_O(raddr), .FILE_WR_O(fwr), .ACC_O(acc),
    .ZERO_WE_O(zwe), .ZERO_O(zero), .PC_LOAD_O(pcl), .PC_VALUE_O(pcv), .STACK_PUSH_O(push),
    .STACK_TOP_O(top), .SKIP_O(skip), .PRESCALER_CLR_O(pclr), .BUSY_O(busy)
  );

  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic run(input lbtce_row_t r);
    @(negedge mclk);
    instr = '{1'h1, r.w};
    frd = r.fd;
    is_port = r.port;
    pin = r.pin;
    @(negedge mclk);
    instr.valid = 1'h0;
    chk(fwr.we, r.we);
    if (r.we) chk({fwr.addr, fwr.data}, {r.w[4:0], r.data});
    chk(zwe, r.zwe);
    if (r.zwe) chk(zero, 1'h1);
    chk(acc, 8'h00);
    chk({skip, busy}, {r.skip, r.skip});
    chk(pclr, r.pclr);
    chk({pcl, push}, 2'h0);
  endtask : run

  // The slot after a call carries a bit-set that must be dropped.
  task automatic call_k(input logic [7:0] st, input logic [10:0] p, input logic [7:0] k,
                        input logic [10:0] exp_pc, input logic [10:0] exp_top);
    @(negedge mclk);
    status = st;
    pc = p;
    instr = '{1'h1, {OPC_CALL, k}};
    @(negedge mclk);
    instr.word = 12'h5E4;
    chk({pcl, push, busy, zwe}, 4'hE);
    chk(pcv, exp_pc);
    chk(top, exp_top);
    @(negedge mclk);
    instr.valid = 1'h0;
    chk({fwr.we, pcl, push, busy}, 4'h0);
  endtask : call_k

  initial begin
    #(MCLK_PERIOD_NS * 2000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst = 1'h1;
    instr = '{1'h0, 12'h000};
    pc = 11'h000;
    status = 8'h00;
    frd = 8'h00;
    pin = 8'h00;
    is_port = 1'h0;
    pre_on = 1'h1;
    repeat (20) @(negedge mclk);
    chk({fwr.we, zwe, pcl, push, skip, pclr, busy, acc}, 15'h0000);
    rst = 1'h0;
    @(negedge mclk);
    chk({fwr.we, zwe, pcl, push, skip, pclr, busy, top}, 18'h00000);
    foreach (ROWS[i]) run(ROWS[i]);
    call_k(8'h7F, 11'h123, 8'hAB, 11'h6AB, 11'h124);
    call_k(8'h20, 11'h3FE, 8'h00, 11'h200, 11'h3FF);
    pre_on = 1'h0;
    run('{12'h521, 8'h00, 1'h0, 8'h00, 1'h1, 8'h02, 1'h0, 1'h0, 1'h0});
    @(negedge mclk);
    instr = '{1'h1, 12'h605};
    frd = 8'h00;
    @(negedge mclk);
    instr.word = 12'h5E4;
    chk({skip, busy}, 2'h3);
    @(negedge mclk);
    chk({fwr.we, skip, busy}, 3'h0);
    instr.word = 12'h504;
    frd = 8'h10;
    @(negedge mclk);
    chk({fwr.we, fwr.addr, fwr.data}, {1'h1, 5'h04, 8'h11});
    instr.word = 12'h527;
    frd = 8'h00;
    @(negedge mclk);
    instr.valid = 1'h0;
    chk({fwr.we, fwr.addr, fwr.data}, {1'h1, 5'h07, 8'h02});
    // A reset inside the second cycle of a call must empty the stack and free the slot at once.
    @(negedge mclk);
    instr = '{1'h1, {OPC_CALL, 8'h55}};
    @(negedge mclk);
    rst = 1'h1;
    instr.word = OPC_CLEAR_ACC;
    @(negedge mclk);
    chk({fwr.we, zwe, zero, pcl, push, skip, pclr, busy, acc, top}, 27'h0000000);
    rst = 1'h0;
    @(negedge mclk);
    instr.valid = 1'h0;
    chk({zwe, zero, busy, acc}, 11'h600);
    report_and_stop();
  end
endmodule : tb
